// ===== core/dgs_map.svh
`ifndef DGS_MAP_SVH
`define DGS_MAP_SVH

// setting codes and limits
`define DGS_NOT_SET 14'h270f
`define DGS_PCT_MAX 14'h0064
`define DGS_GAIN_MAX 14'h03e8
`define DGS_DIA_MIN 14'h0001
`define DGS_DIA_MAX 14'h1999
`define DGS_PCT1_DEFAULT 32'h0000_0021
`define DGS_PCT2_DEFAULT 32'h0000_0042
`define DGS_SET_NEEDED 3'h2
`define DGS_PCT_DIV 32'h0000_000a
`define DGS_MM_TO_TENTHS 32'h0000_000a
`define DGS_ANA_SCALE 32'h0000_0064
`define DGS_ANA_FULL 32'h0000_03e8

// reset values of the settings
`define DGS_TARGET_RESET 14'h0001
`define DGS_MIN_DIA_RESET 14'h0001
`define DGS_MAX_DIA_RESET 14'h03e8
`define DGS_MON_REF_RESET 14'h03e8
`define DGS_NORMAL_GAIN_RESET 14'h0064

// output terminal and monitor selection codes
`define DGS_TERM_POS 8'h34
`define DGS_TERM_NEG 8'h98
`define DGS_SEL_VOLTS 8'h1a
`define DGS_SEL_PCT 8'h1b
`define DGS_SEL_DIA 8'h28
`define DGS_SEL_SETPOINT 8'h34
`define DGS_SEL_MEASURED 8'h35
`define DGS_SEL_DEVIATION 8'h36

// monitor register offsets
`define DGS_REG_VOLTS 16'h9d22
`define DGS_REG_PCT 16'h9d23
`define DGS_REG_TENSION 16'h9d2f
`define DGS_REG_DIA 16'h9d30
`define DGS_REG_MAIN_SPEED 16'h9d31
`define DGS_REG_LINE_SPEED 16'h9d32
`define DGS_REG_DANCER_COMP 16'h9d33
`define DGS_REG_DIA_COMP 16'h9d34
`define DGS_REG_LENGTH 16'h9d35
`define DGS_REG_TENSION2 16'h9d36
`define DGS_REG_SETPOINT 16'h9d3c
`define DGS_REG_MEASURED 16'h9d3d
`define DGS_REG_DEVIATION 16'h9d3e
`define DGS_REG_PULSE 16'h9d46
`define DGS_REG_TENSION_CMD 16'h9d47
`define DGS_REG_MECH_LOSS 16'h9d48
`define DGS_REG_INERTIA 16'h9d49
`define DGS_MON_COUNT 17
`define DGS_MON_LAST 5'h10
`define DGS_IDX_DIA 5'h03

`endif

// ===== core/dgs_pkg.sv
package dgs_pkg;

	typedef struct packed {
		logic [13:0] applied_dia1;
		logic [13:0] applied_dia2;
		logic [13:0] gain1;
		logic [13:0] gain2;
		logic [13:0] gain3;
		logic [13:0] gain4;
		logic [13:0] normal_gain1;
		logic [13:0] normal_gain2;
		logic [13:0] target_dia;
		logic [13:0] min_dia;
		logic [13:0] max_dia;
		logic [13:0] dia_mon_ref;
	} dgs_settings_s;

	typedef struct packed {
		logic [15:0] dancer_input_volts;
		logic [15:0] dancer_input_pct;
		logic [15:0] tension_cmd;
		logic [15:0] main_speed;
		logic [15:0] line_speed;
		logic [15:0] dancer_comp_speed;
		logic [15:0] diameter_comp_speed;
		logic [15:0] wound_length;
		logic [15:0] tension_cmd2;
		logic [15:0] dancer_setpoint;
		logic [15:0] dancer_measured;
		logic [15:0] dancer_deviation;
		logic [15:0] line_pulse_rate;
		logic [15:0] tension_command;
		logic [15:0] mech_loss_comp;
		logic [15:0] inertia_comp;
	} dgs_mon_in_s;

	typedef enum logic [1:0] {
		DGS_BP1 = 2'b00,
		DGS_BP2 = 2'b01,
		DGS_GAIN = 2'b10,
		DGS_ANA = 2'b11
	} dgs_step_e;

	typedef struct packed {
		dgs_settings_s set;
		dgs_step_e step;
		logic started;
		logic div_start;
		logic [31:0] div_num;
		logic [31:0] div_den;
		logic [31:0] bp1;
		logic [31:0] bp2;
		logic [31:0] base;
		logic add;
		logic [13:0] dia_gain;
		logic [13:0] p_gain;
		logic gain_active;
		logic reached;
		logic term_out;
		logic [15:0] panel;
		logic [15:0] analog;
		logic [4:0] wr_idx;
		logic rvalid;
		logic rerr;
	} dgs_core_st_s;

endpackage

// ===== core/dgs_divider.sv
module dgs_divider #(
	parameter int W = 32
) (
	input wire logic clock,
	input wire logic reset_n,
	input wire logic start,
	input wire logic [W-1:0] num,
	input wire logic [W-1:0] den,
	output logic done,
	output logic [W-1:0] quot
);
	localparam int CW = $clog2(W) + 1;

	typedef struct packed {
		logic busy;
		logic done;
		logic [CW-1:0] cnt;
		logic [W-1:0] rem;
		logic [W-1:0] quo;
	} dgs_div_st_s;

	dgs_div_st_s st_q;
	dgs_div_st_s st_d;
	logic [W:0] rem_sh;

	initial begin
		if (W < 2) begin
			$error("divider width too small");
		end
	end

	// one quotient bit per cycle; a zero divisor must be kept out by the caller
	always_comb begin
		st_d = st_q;
		st_d.done = 1'b0;
		rem_sh = {st_q.rem, st_q.quo[W-1]};
		if (start && !st_q.busy) begin
			st_d.busy = 1'b1;
			st_d.cnt = CW'(W - 1);
			st_d.rem = '0;
			st_d.quo = num;
		end else if (st_q.busy) begin
			st_d.quo = {st_q.quo[W-2:0], 1'b0};
			if (rem_sh >= {1'b0, den}) begin
				st_d.rem = W'(rem_sh - {1'b0, den});
				st_d.quo[0] = 1'b1;
			end else begin
				st_d.rem = rem_sh[W-1:0];
			end
			if (st_q.cnt == '0) begin
				st_d.busy = 1'b0;
				st_d.done = 1'b1;
			end else begin
				st_d.cnt = st_q.cnt - 1'b1;
			end
		end
	end

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	assign done = st_q.done;
	assign quot = st_q.quo;
endmodule // dgs_divider

// ===== core/dgs_mon_mem.sv
module dgs_mon_mem #(
	parameter int DEPTH = 17,
	parameter int WIDTH = 16
) (
	input wire logic clock,
	input wire logic reset_n,
	input wire logic wr_en,
	input wire logic [4:0] wr_idx,
	input wire logic [WIDTH-1:0] wr_data,
	input wire logic rd_en,
	input wire logic [4:0] rd_idx,
	output logic [WIDTH-1:0] rd_data
);
	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [WIDTH-1:0] rdata;
	} dgs_mem_st_s;

	dgs_mem_st_s st_q;
	dgs_mem_st_s st_d;

	initial begin
		if (DEPTH > 32 || DEPTH < 1) begin
			$error("monitor depth out of range");
		end
	end

	// an out-of-range read index returns zero
	always_comb begin
		st_d = st_q;
		if (wr_en && 32'(wr_idx) < DEPTH) begin
			st_d.mem[wr_idx] = wr_data;
		end
		if (rd_en) begin
			st_d.rdata = (32'(rd_idx) < DEPTH) ? st_q.mem[rd_idx] : '0;
		end
	end

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	assign rd_data = st_q.rdata;
endmodule // dgs_mon_mem

// ===== core/dgs_gain_select.sv
`include "dgs_map.svh"
module dgs_gain_select (
	input wire logic clock,
	input wire logic reset_n,
	input wire dgs_pkg::dgs_settings_s settings,
	input wire logic settings_wr,
	input wire logic [15:0] winding_dia,
	input wire logic diam_calc_enable,
	input wire logic vector_mode,
	input wire logic diameter_gain_disable_in,
	input wire logic second_set_select_in,
	input wire logic [7:0] out_term_code,
	input wire dgs_pkg::dgs_mon_in_s mon_in,
	input wire logic [7:0] panel_select_code,
	input wire logic [15:0] reg_addr,
	input wire logic reg_rd,
	output logic [13:0] speed_p_gain,
	output logic diameter_gain_active,
	output logic target_diameter_reached_out,
	output logic output_terminal,
	output logic [15:0] front_panel_display,
	output logic [15:0] analog_monitor_output,
	output logic [15:0] reg_rdata,
	output logic reg_rvalid,
	output logic reg_err
);
	dgs_pkg::dgs_core_st_s st_q;
	dgs_pkg::dgs_core_st_s st_d;

	logic div_done;
	logic [31:0] div_quot;
	logic [15:0] dia_mon;
	logic [`DGS_MON_COUNT-1:0][15:0] mon_vals;
	logic [4:0] rd_idx;
	logic rd_hit;
	logic [31:0] min10;
	logic [31:0] max10;
	logic [31:0] dia_c;
	logic [31:0] p1;
	logic [31:0] p2;
	logic [31:0] span;
	logic [13:0] g1;
	logic [13:0] g2;
	logic [13:0] g3;
	logic [13:0] g4;
	logic [13:0] ga;
	logic [13:0] gb;
	logic [31:0] lo;
	logic [31:0] hi;
	logic [2:0] set_cnt;
	logic use_dia;
	logic [13:0] normal_gain;
	logic [31:0] sum;

	function automatic logic pct_ok(input logic [13:0] v);
		return v <= `DGS_PCT_MAX || v == `DGS_NOT_SET;
	endfunction

	function automatic logic gain_ok(input logic [13:0] v);
		return v <= `DGS_GAIN_MAX || v == `DGS_NOT_SET;
	endfunction

	function automatic logic dia_ok(input logic [13:0] v);
		return v >= `DGS_DIA_MIN && v <= `DGS_DIA_MAX;
	endfunction

	dgs_divider #(
		.W(32)
	) u_div (
		.clock(clock),
		.reset_n(reset_n),
		.start(st_q.div_start),
		.num(st_q.div_num),
		.den(st_q.div_den),
		.done(div_done),
		.quot(div_quot)
	);

	dgs_mon_mem #(
		.DEPTH(`DGS_MON_COUNT),
		.WIDTH(16)
	) u_mem (
		.clock(clock),
		.reset_n(reset_n),
		.wr_en(1'b1),
		.wr_idx(st_q.wr_idx),
		.wr_data(mon_vals[st_q.wr_idx]),
		.rd_en(reg_rd),
		.rd_idx(rd_idx),
		.rd_data(reg_rdata)
	);

	// diameter monitor reads zero while the calculation is off
	assign dia_mon = diam_calc_enable ? winding_dia : 16'h0000;

	assign mon_vals = {mon_in.inertia_comp, mon_in.mech_loss_comp, mon_in.tension_command,
		mon_in.line_pulse_rate, mon_in.dancer_deviation, mon_in.dancer_measured,
		mon_in.dancer_setpoint, mon_in.tension_cmd2, mon_in.wound_length,
		mon_in.diameter_comp_speed, mon_in.dancer_comp_speed, mon_in.line_speed,
		mon_in.main_speed, dia_mon, mon_in.tension_cmd, mon_in.dancer_input_pct,
		mon_in.dancer_input_volts};

	always_comb begin
		rd_hit = 1'b1;
		unique case (reg_addr)
			`DGS_REG_VOLTS: rd_idx = 5'h00;
			`DGS_REG_PCT: rd_idx = 5'h01;
			`DGS_REG_TENSION: rd_idx = 5'h02;
			`DGS_REG_DIA: rd_idx = `DGS_IDX_DIA;
			`DGS_REG_MAIN_SPEED: rd_idx = 5'h04;
			`DGS_REG_LINE_SPEED: rd_idx = 5'h05;
			`DGS_REG_DANCER_COMP: rd_idx = 5'h06;
			`DGS_REG_DIA_COMP: rd_idx = 5'h07;
			`DGS_REG_LENGTH: rd_idx = 5'h08;
			`DGS_REG_TENSION2: rd_idx = 5'h09;
			`DGS_REG_SETPOINT: rd_idx = 5'h0a;
			`DGS_REG_MEASURED: rd_idx = 5'h0b;
			`DGS_REG_DEVIATION: rd_idx = 5'h0c;
			`DGS_REG_PULSE: rd_idx = 5'h0d;
			`DGS_REG_TENSION_CMD: rd_idx = 5'h0e;
			`DGS_REG_MECH_LOSS: rd_idx = 5'h0f;
			`DGS_REG_INERTIA: rd_idx = `DGS_MON_LAST;
			default: begin
				rd_idx = 5'h1f;
				rd_hit = 1'b0;
			end
		endcase
	end

	// operands of the gain curve, diameters in 0.1 mm except span, which stays in whole mm
	always_comb begin
		min10 = 32'(st_q.set.min_dia) * `DGS_MM_TO_TENTHS;
		max10 = 32'(st_q.set.max_dia) * `DGS_MM_TO_TENTHS;
		span = (st_q.set.max_dia > st_q.set.min_dia) ?
			32'(st_q.set.max_dia - st_q.set.min_dia) : 32'h0;
		p1 = (st_q.set.applied_dia1 == `DGS_NOT_SET) ?
			`DGS_PCT1_DEFAULT : 32'(st_q.set.applied_dia1);
		p2 = (st_q.set.applied_dia2 == `DGS_NOT_SET) ?
			`DGS_PCT2_DEFAULT : 32'(st_q.set.applied_dia2);
		set_cnt = 3'(st_q.set.gain1 != `DGS_NOT_SET) + 3'(st_q.set.gain2 != `DGS_NOT_SET)
			+ 3'(st_q.set.gain3 != `DGS_NOT_SET) + 3'(st_q.set.gain4 != `DGS_NOT_SET);
		normal_gain = second_set_select_in ?
			st_q.set.normal_gain2 : st_q.set.normal_gain1;
		// an unset curve gain takes the normal gain in force
		g1 = (st_q.set.gain1 == `DGS_NOT_SET) ? normal_gain : st_q.set.gain1;
		g2 = (st_q.set.gain2 == `DGS_NOT_SET) ? normal_gain : st_q.set.gain2;
		g3 = (st_q.set.gain3 == `DGS_NOT_SET) ? normal_gain : st_q.set.gain3;
		g4 = (st_q.set.gain4 == `DGS_NOT_SET) ? normal_gain : st_q.set.gain4;
		use_dia = set_cnt >= `DGS_SET_NEEDED
			&& diam_calc_enable && !diameter_gain_disable_in
			&& vector_mode;
		dia_c = (32'(winding_dia) < min10) ? min10 :
			(32'(winding_dia) > max10) ? max10 : 32'(winding_dia);
		if (dia_c < st_q.bp1) begin
			lo = min10;
			hi = st_q.bp1;
			ga = g1;
			gb = g2;
		end else if (dia_c < st_q.bp2) begin
			lo = st_q.bp1;
			hi = st_q.bp2;
			ga = g2;
			gb = g3;
		end else begin
			lo = st_q.bp2;
			hi = max10;
			// equal breakpoints: the larger of gains 3 and 4 holds there
			ga = (p1 == p2 && g4 > g3) ? g4 : g3;
			gb = g4;
		end
		sum = st_q.add ? st_q.base + div_quot : st_q.base - div_quot;
	end

	always_comb begin
		st_d = st_q;
		st_d.div_start = 1'b0;
		// a setting outside its range is refused and the old value kept
		if (settings_wr) begin
			if (pct_ok(settings.applied_dia1)) st_d.set.applied_dia1 = settings.applied_dia1;
			if (pct_ok(settings.applied_dia2)) st_d.set.applied_dia2 = settings.applied_dia2;
			if (gain_ok(settings.gain1)) st_d.set.gain1 = settings.gain1;
			if (gain_ok(settings.gain2)) st_d.set.gain2 = settings.gain2;
			if (gain_ok(settings.gain3)) st_d.set.gain3 = settings.gain3;
			if (gain_ok(settings.gain4)) st_d.set.gain4 = settings.gain4;
			if (settings.normal_gain1 <= `DGS_GAIN_MAX) st_d.set.normal_gain1 = settings.normal_gain1;
			if (settings.normal_gain2 <= `DGS_GAIN_MAX) st_d.set.normal_gain2 = settings.normal_gain2;
			if (dia_ok(settings.target_dia)) st_d.set.target_dia = settings.target_dia;
			if (dia_ok(settings.min_dia)) st_d.set.min_dia = settings.min_dia;
			if (dia_ok(settings.max_dia)) st_d.set.max_dia = settings.max_dia;
			if (dia_ok(settings.dia_mon_ref)) st_d.set.dia_mon_ref = settings.dia_mon_ref;
		end
		// the curve is recomputed in a loop; each step costs one division
		if (!st_q.started) begin
			st_d.started = 1'b1;
			st_d.div_start = 1'b1;
			st_d.add = 1'b1;
			unique case (st_q.step)
				dgs_pkg::DGS_BP1: begin
					st_d.div_num = span * p1;
					st_d.div_den = `DGS_PCT_DIV;
					st_d.base = min10;
				end
				dgs_pkg::DGS_BP2: begin
					st_d.div_num = span * p2;
					st_d.div_den = `DGS_PCT_DIV;
					st_d.base = min10;
				end
				dgs_pkg::DGS_GAIN: begin
					st_d.base = 32'(ga);
					st_d.add = gb >= ga;
					st_d.div_den = (hi > lo) ? hi - lo : 32'h1;
					st_d.div_num = (hi > lo) ? 32'(st_d.add ? gb - ga : ga - gb) * (dia_c - lo)
						: 32'h0;
				end
				dgs_pkg::DGS_ANA: begin
					st_d.div_num = 32'(dia_mon) * `DGS_ANA_SCALE;
					st_d.div_den = 32'(st_q.set.dia_mon_ref);
					st_d.base = 32'h0;
				end
			endcase
		end else if (div_done) begin
			st_d.started = 1'b0;
			unique case (st_q.step)
				dgs_pkg::DGS_BP1: begin
					st_d.bp1 = sum;
					st_d.step = dgs_pkg::DGS_BP2;
				end
				dgs_pkg::DGS_BP2: begin
					st_d.bp2 = sum;
					st_d.step = dgs_pkg::DGS_GAIN;
				end
				dgs_pkg::DGS_GAIN: begin
					st_d.dia_gain = sum[13:0];
					st_d.step = dgs_pkg::DGS_ANA;
				end
				dgs_pkg::DGS_ANA: begin
					st_d.analog = (sum > `DGS_ANA_FULL) ? 16'(`DGS_ANA_FULL) : sum[15:0];
					st_d.step = dgs_pkg::DGS_BP1;
				end
			endcase
		end
		st_d.gain_active = use_dia;
		st_d.p_gain = use_dia ? st_q.dia_gain : normal_gain;
		st_d.reached = 18'(winding_dia) > 18'(st_q.set.target_dia) * 18'(`DGS_MM_TO_TENTHS);
		st_d.term_out = (out_term_code == `DGS_TERM_POS) ? st_d.reached :
			(out_term_code == `DGS_TERM_NEG) ? !st_d.reached : 1'b0;
		unique case (panel_select_code)
			`DGS_SEL_VOLTS: st_d.panel = mon_in.dancer_input_volts;
			`DGS_SEL_PCT: st_d.panel = mon_in.dancer_input_pct;
			`DGS_SEL_DIA: st_d.panel = dia_mon;
			`DGS_SEL_SETPOINT: st_d.panel = mon_in.dancer_setpoint;
			`DGS_SEL_MEASURED: st_d.panel = mon_in.dancer_measured;
			`DGS_SEL_DEVIATION: st_d.panel = mon_in.dancer_deviation;
			default: st_d.panel = 16'h0000;
		endcase
		// monitor copies refresh one word per cycle, so reads lag by up to 17 cycles
		st_d.wr_idx = (st_q.wr_idx == `DGS_MON_LAST) ? 5'h00 : st_q.wr_idx + 5'h01;
		st_d.rvalid = reg_rd;
		st_d.rerr = reg_rd && !rd_hit;
	end

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			st_q <= '0;
			st_q.set.applied_dia1 <= `DGS_NOT_SET;
			st_q.set.applied_dia2 <= `DGS_NOT_SET;
			st_q.set.gain1 <= `DGS_NOT_SET;
			st_q.set.gain2 <= `DGS_NOT_SET;
			st_q.set.gain3 <= `DGS_NOT_SET;
			st_q.set.gain4 <= `DGS_NOT_SET;
			st_q.set.normal_gain1 <= `DGS_NORMAL_GAIN_RESET;
			st_q.set.normal_gain2 <= `DGS_NORMAL_GAIN_RESET;
			st_q.set.target_dia <= `DGS_TARGET_RESET;
			st_q.set.min_dia <= `DGS_MIN_DIA_RESET;
			st_q.set.max_dia <= `DGS_MAX_DIA_RESET;
			st_q.set.dia_mon_ref <= `DGS_MON_REF_RESET;
			st_q.p_gain <= `DGS_NORMAL_GAIN_RESET;
			st_q.step <= dgs_pkg::DGS_BP1;
		end else begin
			st_q <= st_d;
		end
	end

	assign speed_p_gain = st_q.p_gain;
	assign diameter_gain_active = st_q.gain_active;
	assign target_diameter_reached_out = st_q.reached;
	assign output_terminal = st_q.term_out;
	assign front_panel_display = st_q.panel;
	assign analog_monitor_output = st_q.analog;
	assign reg_rvalid = st_q.rvalid;
	assign reg_err = st_q.rerr;
endmodule // dgs_gain_select

// ===== verif/dgs_host_model.sv
// stands in for the speed loop: monitor sources hold between loads, as sampled values do
module dgs_host_model (
	input wire logic clock,
	input wire logic reset_n,
	input wire logic load,
	input wire logic [15:0] seed,
	output dgs_pkg::dgs_mon_in_s mon_in
);
	timeunit 1ns;
	timeprecision 1ps;
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n)
			mon_in <= '0;
		else if (load)
			for (int i = 0; i < 16; i++)
				mon_in[i*16 +: 16] <= seed + 16'(i * 257);
	end
endmodule // dgs_host_model

// ===== verif/dgs_gain_select_assertions.sv
`include "dgs_map.svh"
module dgs_chk (
	input wire logic clock,
	input wire logic reset_n,
	input wire dgs_pkg::dgs_settings_s settings,
	input wire logic settings_wr,
	input wire logic [15:0] winding_dia,
	input wire logic diam_calc_enable,
	input wire logic vector_mode,
	input wire logic diameter_gain_disable_in,
	input wire logic second_set_select_in,
	input wire logic [7:0] out_term_code,
	input wire logic [15:0] reg_addr,
	input wire logic reg_rd,
	input wire logic [13:0] speed_p_gain,
	input wire logic diameter_gain_active,
	input wire logic target_diameter_reached_out,
	input wire logic output_terminal,
	input wire logic [15:0] reg_rdata,
	input wire logic reg_rvalid,
	input wire logic reg_err
);
	default clocking cb @(posedge clock); endclocking
	default disable iff (!reset_n);
	logic [13:0] tgt_q, ng1_q, ng2_q;
	logic [13:0] g_q [4];
	logic [2:0] nset;
	logic cond, map_ok;
	function automatic logic gok(logic [13:0] v);
		return v <= `DGS_GAIN_MAX || v == `DGS_NOT_SET;
	endfunction
	// shadow of the settings that the rules compare against; refused values are ignored
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			tgt_q <= `DGS_TARGET_RESET;
			ng1_q <= `DGS_NORMAL_GAIN_RESET;
			ng2_q <= `DGS_NORMAL_GAIN_RESET;
			g_q <= '{default: `DGS_NOT_SET};
		end else if (settings_wr) begin
			if (settings.target_dia >= `DGS_DIA_MIN && settings.target_dia <= `DGS_DIA_MAX)
				tgt_q <= settings.target_dia;
			if (settings.normal_gain1 <= `DGS_GAIN_MAX)
				ng1_q <= settings.normal_gain1;
			if (settings.normal_gain2 <= `DGS_GAIN_MAX)
				ng2_q <= settings.normal_gain2;
			if (gok(settings.gain1))
				g_q[0] <= settings.gain1;
			if (gok(settings.gain2))
				g_q[1] <= settings.gain2;
			if (gok(settings.gain3))
				g_q[2] <= settings.gain3;
			if (gok(settings.gain4))
				g_q[3] <= settings.gain4;
		end
	end
	always_comb begin
		nset = 3'h0;
		for (int i = 0; i < 4; i++)
			nset = nset + 3'(g_q[i] != `DGS_NOT_SET);
	end
	assign cond = nset >= 3'h2 && diam_calc_enable && !diameter_gain_disable_in && vector_mode;
	assign map_ok = reg_addr inside {[16'h9d22:16'h9d23], [16'h9d2f:16'h9d36],
		[16'h9d3c:16'h9d3e], [16'h9d46:16'h9d49]};
	// a write edge is skipped: the new value may land one stage later
	a_reach_diameter: assert property (
		!$past(settings_wr) |->
		target_diameter_reached_out == ($past(winding_dia) > 16'($past(tgt_q)) * 16'h000a))
		else $error("reached flag does not follow diameter against target");
	a_term_positive: assert property (
		out_term_code == `DGS_TERM_POS && $stable(out_term_code)
		&& $stable(target_diameter_reached_out) |-> output_terminal == target_diameter_reached_out)
		else $error("terminal not equal to reached flag");
	a_term_inverted: assert property (
		out_term_code == `DGS_TERM_NEG && $stable(out_term_code)
		&& $stable(target_diameter_reached_out) |-> output_terminal != target_diameter_reached_out)
		else $error("terminal not inverse of reached flag");
	a_term_idle: assert property (
		!(out_term_code inside {`DGS_TERM_POS, `DGS_TERM_NEG}) && $stable(out_term_code)
		|-> !output_terminal)
		else $error("terminal driven without its code");
	a_active_cause: assert property (
		!$past(settings_wr) |-> diameter_gain_active == $past(cond))
		else $error("diameter gain use does not match its conditions");
	a_normal_gain: assert property (
		!diameter_gain_active && !$past(settings_wr) |->
		speed_p_gain == ($past(second_set_select_in) ? $past(ng2_q) : $past(ng1_q)))
		else $error("wrong normal gain applied");
	a_gain_bound: assert property (speed_p_gain <= `DGS_GAIN_MAX)
		else $error("gain above full range");
	a_read_answer: assert property (reg_rd |=> reg_rvalid)
		else $error("read not answered next cycle");
	a_valid_cause: assert property (reg_rvalid |-> $past(reg_rd))
		else $error("read answer without request");
	a_err_unmapped: assert property (reg_rd |=> reg_err != $past(map_ok))
		else $error("error flag wrong for address");
	a_err_zero: assert property (reg_err |-> reg_rdata == 16'h0000)
		else $error("refused read returned data");
	c_active: cover property (diameter_gain_active);
	c_refused: cover property (reg_err);
	c_reached: cover property (output_terminal && target_diameter_reached_out);
endmodule // dgs_chk
bind dgs_gain_select dgs_chk u_dgs_chk (.clock, .reset_n, .settings, .settings_wr, .winding_dia,
	.diam_calc_enable, .vector_mode, .diameter_gain_disable_in, .second_set_select_in,
	.out_term_code, .reg_addr, .reg_rd, .speed_p_gain, .diameter_gain_active,
	.target_diameter_reached_out, .output_terminal, .reg_rdata, .reg_rvalid, .reg_err);

// ===== verif/dgs_gain_select_tb.sv
`include "dgs_map.svh"
`define CHK(got, exp) begin \
	n_checks++; \
	if ((got) !== (exp)) begin \
		n_mismatch++; \
		$display("wrong value at %0t: got %0h expected %0h", $time, got, exp); \
	end \
end
module dgs_gain_select_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic clock, reset_n, settings_wr, calc_en, vec, dis, sel, reg_rd, load;
	logic active, reached, term, reg_rvalid, reg_err;
	logic [15:0] dia, reg_addr, seed, reg_rdata, panel, analog;
	logic [7:0] term_code, pan_code;
	logic [13:0] speed_p_gain;
	dgs_pkg::dgs_settings_s st, settings;
	dgs_pkg::dgs_mon_in_s mon_in;
	int n_mismatch, n_checks, cyc, mn, mx, p1, p2, d, e;
	int g [4];
	int unsigned rs = 59142;
	logic [15:0] ofs [17] = '{16'h9d22, 16'h9d23, 16'h9d2f, 16'h9d30, 16'h9d31, 16'h9d32,
		16'h9d33, 16'h9d34, 16'h9d35, 16'h9d36, 16'h9d3c, 16'h9d3d, 16'h9d3e, 16'h9d46,
		16'h9d47, 16'h9d48, 16'h9d49};
	logic [7:0] pc [7] = '{8'h1a, 8'h1b, 8'h28, 8'h34, 8'h35, 8'h36, 8'h63};
	int pk [7] = '{0, 1, -1, 9, 10, 11, -2};
	logic [7:0] tc [3] = '{8'h34, 8'h98, 8'h07};
	dgs_host_model u_dgs_host_model (.clock(clock), .reset_n(reset_n), .load(load),
		.seed(seed), .mon_in(mon_in));
	dgs_gain_select u_dgs_gain_select (.clock(clock), .reset_n(reset_n), .settings(settings),
		.settings_wr(settings_wr), .winding_dia(dia), .diam_calc_enable(calc_en),
		.vector_mode(vec), .diameter_gain_disable_in(dis), .second_set_select_in(sel),
		.out_term_code(term_code), .mon_in(mon_in), .panel_select_code(pan_code),
		.reg_addr(reg_addr), .reg_rd(reg_rd), .speed_p_gain(speed_p_gain),
		.diameter_gain_active(active), .target_diameter_reached_out(reached),
		.output_terminal(term), .front_panel_display(panel), .analog_monitor_output(analog),
		.reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .reg_err(reg_err));
	function automatic int unsigned rnd();
		rs ^= rs << 13;
		rs ^= rs >> 17;
		rs ^= rs << 5;
		return rs;
	endfunction
	function automatic int monv(int k);
		return (int'(seed) + (15 - k) * 257) & 'hffff;
	endfunction
	function automatic int lin(int x, int xa, int xb, int ga, int gb);
		// a zero-width zone keeps its start gain
		if (xb <= xa)
			return ga;
		return ga + (gb - ga) * (x - xa) / (xb - xa);
	endfunction
	function automatic int mgain(int x);
		int lo, hi, q1, q2, b1, b2;
		lo = mn * 10;
		hi = mx * 10;
		q1 = (p1 == 9999) ? 33 : p1;
		q2 = (p2 == 9999) ? 66 : p2;
		b1 = (mx - mn) * q1 / 10 + lo;
		b2 = (mx - mn) * q2 / 10 + lo;
		x = (x < lo) ? lo : (x > hi) ? hi : x;
		if (x < b1)
			return lin(x, lo, b1, g[0], g[1]);
		if (q1 == q2)
			return lin(x, b2, hi, (g[2] > g[3]) ? g[2] : g[3], g[3]);
		if (x < b2)
			return lin(x, b1, b2, g[1], g[2]);
		return lin(x, b2, hi, g[2], g[3]);
	endfunction
	task automatic close_out();
		$display("checks %0d mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clock);
		#1;
	endtask
	task automatic wset();
		@(posedge clock);
		settings <= st;
		settings_wr <= 1'b1;
		@(posedge clock);
		settings_wr <= 1'b0;
		tick(3);
	endtask
	task automatic rd(input logic [15:0] a, input int ev, input logic ee);
		@(posedge clock);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clock);
		reg_rd <= 1'b0;
		#1;
		`CHK(reg_rvalid, 1'b1)
		`CHK(reg_err, ee)
		`CHK(reg_rdata, ev)
	endtask
	initial begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end
	always @(posedge clock) begin
		cyc++;
		if (cyc == 20000) begin
			n_mismatch++;
			close_out();
		end
	end
	initial begin
		{reset_n, settings_wr, calc_en, vec, dis, sel, reg_rd, load} = '0;
		{dia, reg_addr, seed, term_code, pan_code} = '0;
		st = {{2{`DGS_NOT_SET}}, {4{`DGS_NOT_SET}}, 14'h0064, 14'h0064, 14'h0001, 14'h0001,
			14'h03e8, 14'h03e8};
		settings = st;
		repeat (8) @(posedge clock);
		reset_n <= 1'b1;
		tick(2);
		`CHK(speed_p_gain, 100)
		`CHK(reached, 1'b0)
		// monitors: every register, one unmapped hole, every panel code
		@(posedge clock);
		seed <= 16'(rnd());
		load <= 1'b1;
		dia <= 16'(rnd());
		calc_en <= 1'b1;
		vec <= 1'b1;
		@(posedge clock);
		load <= 1'b0;
		tick(20);
		for (int i = 0; i < 17; i++)
			rd(ofs[i], (i == 3) ? int'(dia) : monv((i < 3) ? i : i - 1), 1'b0);
		rd(16'h9d24, 0, 1'b1);
		for (int i = 0; i < 7; i++) begin
			@(posedge clock);
			pan_code <= pc[i];
			tick(2);
			e = (pk[i] == -1) ? int'(dia) : (pk[i] < 0) ? 0 : monv(pk[i]);
			`CHK(panel, e)
		end
		// the analog value trails the division loop by up to one full round
		tick(200);
		e = int'(dia) * 100 / 1000;
		`CHK(analog, (e > 1000) ? 1000 : e)
		// one curve gain set only: normal gains stay in force
		st.normal_gain1 = 14'h00c8;
		st.normal_gain2 = 14'h012c;
		st.gain1 = 14'h0064;
		wset();
		for (int i = 0; i < 2; i++) begin
			@(posedge clock);
			sel <= i[0];
			tick(2);
			`CHK(active, 1'b0)
			`CHK(speed_p_gain, i ? 300 : 200)
		end
		st.gain2 = 14'h00c8;
		st.gain3 = 14'h0190;
		st.gain4 = 14'h0320;
		st.min_dia = 14'h0064;
		st.max_dia = 14'h044c;
		wset();
		for (int i = 0; i < 8; i++) begin
			@(posedge clock);
			calc_en <= i[0];
			dis <= i[1];
			vec <= i[2];
			tick(2);
			`CHK(active, i == 5)
		end
		mn = 100;
		mx = 1100;
		g = '{100, 200, 400, 800};
		@(posedge clock);
		dis <= 1'b0;
		// the last two passes sit on and above a shared breakpoint
		for (int i = 0; i < 7; i++) begin
			p1 = (i == 0) ? 9999 : (i > 4) ? 50 : rnd() % 101;
			p2 = (i == 0) ? 9999 : (i > 4) ? 50 : p1 + rnd() % (101 - p1);
			d = (i == 5) ? 6000 : (i == 6) ? 6000 + rnd() % 5000 : 900 + rnd() % 10300;
			st.applied_dia1 = 14'(p1);
			st.applied_dia2 = 14'(p2);
			wset();
			@(posedge clock);
			dia <= 16'(d);
			tick(400);
			`CHK(active, 1'b1)
			`CHK(speed_p_gain, mgain(d))
		end
		st.target_dia = 14'h0032;
		wset();
		for (int i = 0; i < 6; i++) begin
			@(posedge clock);
			dia <= 16'(500 + i % 2);
			term_code <= tc[i / 2];
			tick(2);
			`CHK(reached, i[0])
			`CHK(term, (i < 2) ? i[0] : (i < 4) ? !i[0] : 1'b0)
		end
		st.target_dia = 14'h0000;
		wset();
		`CHK(reached, 1'b1)
		st.target_dia = 14'h1999;
		wset();
		@(posedge clock);
		dia <= 16'hfffa;
		tick(2);
		`CHK(reached, 1'b0)
		close_out();
	end
endmodule // dgs_gain_select_tb
